// File: shared/hsc_pkg.sv
package hsc_pkg;
	// ----------------------------------------------------------------
	// core modes and sizes
	// ----------------------------------------------------------------
	localparam int unsigned HSC_SEL_COUNT = 8;
	localparam int unsigned HSC_DATA_BITS = 8;
	localparam logic [2:0] HSC_BIT_LAST = 3'h7;
	localparam logic [2:0] HSC_BIT_RST = 3'h0;
	localparam logic [7:0] HSC_BYTE_RST = 8'h00;
	localparam logic [7:0] HSC_SEL_IDLE = 8'hff;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned HSC_CLK_MHZ = 50;
	localparam int unsigned HSC_HALF_NS = 80;
	localparam int unsigned HSC_HALF_CYC_I = (HSC_HALF_NS * HSC_CLK_MHZ) / 1000;
	localparam logic [3:0] HSC_HALF_CYC = 4'(HSC_HALF_CYC_I);
	localparam logic [3:0] HSC_DIV_RST = 4'h0;

	typedef enum logic [1:0] {
		HSC_IDLE = 2'b00,
		HSC_SHIFT = 2'b01,
		HSC_DONE = 2'b10
	} hsc_state_e;
endpackage

// File: src/hsc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module hsc_sync
	import hsc_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] rst_val,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} hsc_sync_s;

	hsc_sync_s st_q;
	hsc_sync_s st_d;

	// rst_val must be a constant tie at the instance
	always_comb begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
		if (sys_rst) begin
			st_d = '{meta: rst_val, stable: rst_val};
		end
	end

	always_ff @(posedge sys_clk) begin
		st_q <= st_d;
	end

	assign sync_out = st_q.stable;
endmodule
`default_nettype wire

// File: src/hsc_spi_core.sv
`timescale 1ns/100ps
`default_nettype none
module hsc_spi_core
	import hsc_pkg::*;
#(
	parameter bit WAKEUP_EN = 1'b0
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic master_mode,
	input wire logic start,
	input wire logic [2:0] sel_index,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic busy,
	output logic flash_access,
	input wire logic irq_ack,
	output logic irq,
	input wire logic standby_req,
	output logic standby_out,
	output logic wake_out,
	input wire logic spi_clk_i,
	output logic spi_clk_o,
	output logic spi_clk_oe,
	input wire logic spi_miso_i,
	output logic spi_miso_o,
	output logic spi_miso_oe,
	input wire logic spi_mosi_i,
	output logic spi_mosi_o,
	output logic spi_mosi_oe,
	output logic [7:0] spi_sel_n,
	input wire logic spi_slave_sel_n,
	input wire logic flash_select_n
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		hsc_state_e state;
		logic is_master;
		logic sck;
		logic [3:0] div;
		logic [2:0] bitcnt;
		logic [7:0] sh;
		logic [7:0] rx;
		logic rx_valid;
		logic [7:0] sel_n;
		logic mosi;
		logic miso;
		logic sck_prev;
		logic flash;
		logic irq;
		logic standby;
		logic wake;
	} hsc_core_s;

	hsc_core_s st_q;
	hsc_core_s st_d;

	logic [4:0] pins_sync;
	logic s_clk;
	logic s_miso;
	logic s_mosi;
	logic s_ssn;
	logic s_fsn;
	logic s_active;
	logic s_rise;
	logic s_fall;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	hsc_sync #(.WIDTH(5)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async_in({spi_clk_i, spi_miso_i, spi_mosi_i, spi_slave_sel_n, flash_select_n}),
		.rst_val(5'h03),
		.sync_out(pins_sync)
	);

	assign {s_clk, s_miso, s_mosi, s_ssn, s_fsn} = pins_sync;
	// either select opens a slave frame
	assign s_active = !s_ssn || !s_fsn;
	assign s_rise = s_clk && !st_q.sck_prev;
	assign s_fall = !s_clk && st_q.sck_prev;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.sck_prev = s_clk;
		st_d.rx_valid = 1'b0;
		// ack clears, completion below sets and wins
		if (irq_ack) begin
			st_d.irq = 1'b0;
		end
		// power outputs gated by the build option
		st_d.standby = WAKEUP_EN && standby_req;
		st_d.wake = WAKEUP_EN && !standby_req && st_q.standby;
		case (st_q.state)
			HSC_IDLE: begin
				st_d.sck = 1'b0;
				st_d.div = HSC_DIV_RST;
				st_d.bitcnt = HSC_BIT_RST;
				st_d.sel_n = HSC_SEL_IDLE;
				st_d.is_master = master_mode;
				if (master_mode && start) begin
					// one low select out of eight
					st_d.sel_n = ~(8'h01 << sel_index);
					st_d.sh = tx_byte;
					st_d.mosi = tx_byte[7];
					st_d.state = HSC_SHIFT;
				end else if (!master_mode && s_active) begin
					st_d.sh = tx_byte;
					st_d.miso = tx_byte[7];
					st_d.flash = !s_fsn;
					st_d.state = HSC_SHIFT;
				end
			end
			HSC_SHIFT: begin
				if (st_q.is_master) begin
					if (st_q.div == HSC_HALF_CYC - 4'h1) begin
						st_d.div = HSC_DIV_RST;
						st_d.sck = !st_q.sck;
						if (!st_q.sck) begin
							st_d.sh = {st_q.sh[6:0], s_miso};
						end else begin
							st_d.bitcnt = st_q.bitcnt + 3'h1;
							st_d.mosi = st_q.sh[7];
							if (st_q.bitcnt == HSC_BIT_LAST) begin
								st_d.state = HSC_DONE;
							end
						end
					end else begin
						st_d.div = st_q.div + 4'h1;
					end
				end else if (!s_active) begin
					// frame dropped early, partial byte discarded
					st_d.state = HSC_IDLE;
				end else if (s_rise) begin
					st_d.sh = {st_q.sh[6:0], s_mosi};
					st_d.bitcnt = st_q.bitcnt + 3'h1;
					if (st_q.bitcnt == HSC_BIT_LAST) begin
						st_d.state = HSC_DONE;
					end
				end else if (s_fall) begin
					st_d.miso = st_q.sh[7];
				end
			end
			HSC_DONE: begin
				st_d.rx = st_q.sh;
				st_d.rx_valid = 1'b1;
				st_d.irq = 1'b1;
				st_d.sel_n = HSC_SEL_IDLE;
				st_d.state = HSC_IDLE;
			end
			default: begin
				st_d.state = HSC_IDLE;
			end
		endcase
		if (sys_rst) begin
			st_d = '0;
			st_d.state = HSC_IDLE;
			st_d.sel_n = HSC_SEL_IDLE;
			st_d.rx = HSC_BYTE_RST;
			st_d.sh = HSC_BYTE_RST;
			// idle clock level, so no false edge right after reset
			st_d.sck_prev = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// pin direction follows mode
	assign spi_clk_oe = st_q.is_master;
	assign spi_clk_o = st_q.sck;
	assign spi_mosi_oe = st_q.is_master;
	assign spi_mosi_o = st_q.mosi;
	// only the selected slave drives its output
	assign spi_miso_oe = !st_q.is_master && (st_q.state == HSC_SHIFT);
	assign spi_miso_o = st_q.miso;
	assign spi_sel_n = st_q.sel_n;
	assign rx_byte = st_q.rx;
	assign rx_valid = st_q.rx_valid;
	assign busy = st_q.state != HSC_IDLE;
	assign flash_access = st_q.flash;
	assign irq = st_q.irq;
	assign standby_out = st_q.standby;
	assign wake_out = st_q.wake;
endmodule
`default_nettype wire

// File: verification/hsc_spi_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hsc_spi_core_sva #(parameter bit WAKEUP_EN = 1'b0) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic rx_valid,
	input wire logic irq,
	input wire logic standby_out,
	input wire logic wake_out,
	input wire logic spi_clk_oe,
	input wire logic spi_miso_oe,
	input wire logic spi_mosi_oe,
	input wire logic [7:0] spi_sel_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_clk; spi_clk_oe |-> !spi_miso_oe; endproperty
	a_clk: assert property (p_clk) else $error("clk");
	property p_miso; spi_miso_oe |-> spi_sel_n == 8'hff; endproperty
	a_miso: assert property (p_miso) else $error("miso");
	property p_mosi; spi_sel_n != 8'hff |-> spi_mosi_oe; endproperty
	a_mosi: assert property (p_mosi) else $error("mosi");
	property p_sel; spi_sel_n != 8'hff |-> spi_clk_oe && $onehot(~spi_sel_n); endproperty
	a_sel: assert property (p_sel) else $error("sel");
	property p_wake; !WAKEUP_EN |-> !standby_out && !wake_out; endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_irq; rx_valid |-> irq; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	cover property (rx_valid && spi_clk_oe);
	cover property (rx_valid && !spi_clk_oe);
	cover property (spi_sel_n == 8'h7f);
endmodule
bind hsc_spi_core hsc_spi_core_sva #(.WAKEUP_EN(WAKEUP_EN)) hsc_spi_core_sva_i (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.rx_valid(rx_valid),
	.irq(irq),
	.standby_out(standby_out),
	.wake_out(wake_out),
	.spi_clk_oe(spi_clk_oe),
	.spi_miso_oe(spi_miso_oe),
	.spi_mosi_oe(spi_mosi_oe),
	.spi_sel_n(spi_sel_n)
);
`default_nettype wire

// File: verification/hsc_spi_peer.sv
`timescale 1ns/100ps
`default_nettype none
module hsc_spi_peer (
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	logic [7:0] sh;
	logic sel_q = 1'b1;
	// one process owns miso: load on select, shift on falling clock
	always @(sel_n, negedge sck) begin
		if (sel_n !== sel_q) begin
			sel_q = sel_n;
			// released line must not keep the last bit
			if (sel_n) miso = ~miso;
			else {miso, sh} = {reply[7], reply};
		end else if (!sel_n && !sck) begin
			{miso, sh} = {sh[6], sh << 1};
		end
	end
	always @(posedge sck) if (!sel_n) got = {got[6:0], mosi};
endmodule
`default_nettype wire

// File: verification/hsc_spi_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module hsc_spi_core_tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst, master_mode, start, irq_ack, standby_req, lk, tb_mosi, peer_miso;
	logic rx_valid, busy, flash_access, irq, standby_out, wake_out, spi_slave_sel_n, flash_select_n;
	logic spi_clk_o, spi_clk_oe, spi_miso_o, spi_miso_oe, spi_mosi_o, spi_mosi_oe;
	logic [2:0] sel_index;
	logic [7:0] tx_byte, rx_byte, spi_sel_n, reply, got, rxm;
	int failures = 0, tests_run = 0;
	wire logic spi_clk_i = spi_clk_oe ? spi_clk_o : lk;
	wire logic spi_miso_i = spi_miso_oe ? spi_miso_o : peer_miso;
	wire logic spi_mosi_i = spi_mosi_oe ? spi_mosi_o : tb_mosi;
	wire logic peer_sel_n = &spi_sel_n;
	// standby and wake reach nothing but the checks
	hsc_spi_core hsc_spi_core_i (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.master_mode(master_mode),
		.start(start),
		.sel_index(sel_index),
		.tx_byte(tx_byte),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid),
		.busy(busy),
		.flash_access(flash_access),
		.irq_ack(irq_ack),
		.irq(irq),
		.standby_req(standby_req),
		.standby_out(standby_out),
		.wake_out(wake_out),
		.spi_clk_i(spi_clk_i),
		.spi_clk_o(spi_clk_o),
		.spi_clk_oe(spi_clk_oe),
		.spi_miso_i(spi_miso_i),
		.spi_miso_o(spi_miso_o),
		.spi_miso_oe(spi_miso_oe),
		.spi_mosi_i(spi_mosi_i),
		.spi_mosi_o(spi_mosi_o),
		.spi_mosi_oe(spi_mosi_oe),
		.spi_sel_n(spi_sel_n),
		.spi_slave_sel_n(spi_slave_sel_n),
		.flash_select_n(flash_select_n)
	);
	hsc_spi_peer hsc_spi_peer_i (
		.sck(spi_clk_i),
		.sel_n(peer_sel_n),
		.mosi(spi_mosi_i),
		.reply(reply),
		.miso(peer_miso),
		.got(got)
	);
	initial forever #10 sys_clk = ~sys_clk;
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) failures++;
		if (s !== e) $display("[ERR] %0t %h %h", $time, s, e);
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// rx_valid stands a whole cycle, so one falling edge always sees it
	task automatic irq_done;
		for (int k = 0; k < 300 && rx_valid !== 1'b1; k++) cyc(1);
		chk({rx_valid, irq}, 2'h3);
		irq_ack = 1'b1;
		cyc(1);
		irq_ack = 1'b0;
		cyc(1);
		chk(irq, 1'b0);
	endtask
	task automatic mst_byte(input logic [2:0] idx, input logic [7:0] b, input logic [7:0] r);
		{reply, tx_byte, sel_index, start} = {r, b, idx, 1'b1};
		cyc(1);
		start = 1'b0;
		cyc(8);
		chk(spi_sel_n, ~(8'h01 << idx));
		chk({busy, spi_clk_oe, spi_mosi_oe, spi_miso_oe}, 4'he);
		irq_done();
		chk(rx_byte, r);
		chk(got, b);
		chk(spi_sel_n, 8'hff);
		chk(busy, 1'b0);
	endtask
	task automatic rst_mid;
		{tx_byte, sel_index, start} = {8'h5a, 3'h2, 1'b1};
		cyc(1);
		start = 1'b0;
		cyc(20);
		sys_rst = 1'b1;
		cyc(2);
		sys_rst = 1'b0;
		chk({busy, irq, rx_valid, spi_clk_o}, 4'h0);
		chk(spi_sel_n, 8'hff);
		cyc(2);
		chk({busy, irq, rx_valid, spi_clk_o}, 4'h0);
		chk(spi_sel_n, 8'hff);
	endtask
	task automatic slv_byte(input logic fl, input logic [7:0] b, input logic [7:0] t);
		{tx_byte, standby_req, flash_select_n, spi_slave_sel_n} = {t, 1'b1, !fl, fl};
		cyc(8);
		for (int i = 7; i >= 0; i--) begin
			tb_mosi = b[i];
			cyc(4);
			if (i == 3) begin
				chk({busy, spi_clk_oe, spi_mosi_oe, spi_miso_oe}, 4'h9);
			end
			{lk, rxm} = {1'b1, rxm[6:0], spi_miso_i};
			cyc(4);
			lk = 1'b0;
		end
		irq_done();
		chk(rx_byte, b);
		chk(rxm, t);
		chk({spi_clk_oe, flash_access, standby_out}, {1'b0, fl, 1'b0});
		{standby_req, flash_select_n, spi_slave_sel_n, tb_mosi} = {3'b011, !tb_mosi};
		cyc(1);
		chk(wake_out, 1'b0);
		cyc(3);
		chk({busy, spi_miso_oe}, 2'h0);
	endtask
	initial begin
		{sys_rst, master_mode, start, irq_ack, standby_req, lk, tb_mosi} = 7'h60;
		{spi_slave_sel_n, flash_select_n, sel_index, tx_byte, reply} = {2'b11, 19'h0};
		cyc(4);
		sys_rst = 1'b0;
		chk(spi_sel_n, 8'hff);
		for (int i = 0; i < 8; i++) mst_byte(3'(i), 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
		rst_mid();
		mst_byte(3'h7, 8'h0f, 8'hf0);
		master_mode = 1'b0;
		slv_byte(1'b0, 8'h96, 8'h4b);
		slv_byte(1'b1, 8'h69, 8'hd2);
		tally_and_finish();
	end
	initial begin
		cyc(5000);
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
